// [hw/ods_frame_fifo.sv]
// synchronous frame FIFO with valid/ready on both sides
`timescale 1ns/1ps
module ods_frame_fifo
  import ods_pkg::*;
#(
  parameter int WIDTH = ODS_FRAME_BITS,
  parameter int DEPTH = ODS_FIFO_DEPTH
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } ods_fifo_state_s;

  ods_fifo_state_s q;
  ods_fifo_state_s d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign empty = (q.wrPtr == q.rdPtr);
  assign full = (q.wrPtr[AW] != q.rdPtr[AW]) && (q.wrPtr[AW-1:0] == q.rdPtr[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[q.rdPtr[AW-1:0]];
  assign push = inValid && !full;
  assign pop = outReady && !empty;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.wrPtr = q.wrPtr + 1'b1;
    end
    if (pop)
    begin
      d.rdPtr = q.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[q.wrPtr[AW-1:0]] <= inData;
    end
  end

endmodule : ods_frame_fifo

// [hw/ods_pkg.sv]
// shared constants and types of the octal converter serial command port
package ods_pkg;

  // frame layout: channel-select byte first, then data byte
  localparam int ODS_FRAME_BITS = 16;
  localparam int ODS_BYTE_BITS = 8;
  localparam int ODS_CH_COUNT = 8;
  localparam int ODS_SEL_MSB = 15;
  localparam int ODS_SEL_LSB = 8;
  localparam int ODS_DATA_MSB = 7;
  localparam int ODS_DATA_LSB = 0;

  // data-byte bit that separates no-operation from a mode write
  localparam int ODS_MODE_FLAG_BIT = 7;

  // output_stage_mode register: width and field positions
  localparam int ODS_MODE_BITS = 6;
  localparam int ODS_MODE_FULL_HI_POS = 0;
  localparam int ODS_MODE_EN_67_POS = 1;
  localparam int ODS_MODE_EN_45_POS = 2;
  localparam int ODS_MODE_FULL_LO_POS = 3;
  localparam int ODS_MODE_EN_23_POS = 4;
  localparam int ODS_MODE_EN_01_POS = 5;

  // reset values
  localparam logic [5:0] ODS_MODE_RESET = 6'h00;
  localparam logic [7:0] ODS_CODE_RESET = 8'h00;

  // command buffer between the frame capture and the command decode and register update
  localparam int ODS_FIFO_DEPTH = 16;

  // synchroniser length for signals entering a clock domain
  localparam int ODS_SYNC_STAGES = 2;

  typedef struct packed {
    logic [7:0] chanSel;
    logic [7:0] data;
  } ods_frame_s;

  typedef enum logic [1:0] {
    ODS_CMD_NOP,
    ODS_CMD_LOAD,
    ODS_CMD_MODE
  } ods_cmd_e;

endpackage : ods_pkg

// [hw/ods_serial_port.sv]
// serial command port of an octal 8-bit converter: shift chain and command decode
// Operation
// - frame is select byte then data, MSB first
// - each rising clock while selected and powered up shifts input into stage one
// - serial output repeats input sixteen clocks later
// - select rising edge applies frame, clock ignored
// - all-zero select with data bit7 low: no-op
// - selected channels load the data byte
// - select bit n addresses channel n
// - channel loads leave mode bits untouched
// - zero select, bit7 high writes mode bits
// - enable bits 5,4,2,1 cover channel pairs
// - mode bits 3 and 0 pick full/half
// - full/half only counts for enabled pairs
// - shift only while selected and powered up
// - serial output changes on rising clock
`timescale 1ns/1ps
module ods_serial_port
  import ods_pkg::*;
#(
  parameter int CH_COUNT = ODS_CH_COUNT,
  parameter int FIFO_DEPTH = ODS_FIFO_DEPTH
)(
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link, clocked by the controller
  input wire logic sclk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  input wire logic power_down_n,
  // open-drain serial output
  output logic serialOutOut,
  output logic serialOutOe,
  // update side
  input wire logic updateHold,
  output logic cmdReady,
  // converter state
  output logic [CH_COUNT-1:0][7:0] chanCode,
  output logic [ODS_MODE_BITS-1:0] output_stage_mode,
  output logic [CH_COUNT-1:0] chanBuffered,
  output logic [CH_COUNT-1:0] chanFullBuffered
);

  // link-domain state, clocked by the serial clock
  typedef struct packed {
    logic [ODS_SYNC_STAGES-1:0] rstSync;
    logic [ODS_FRAME_BITS-1:0] shift;
    logic outOe;
  } ods_link_s;

  // system-domain state
  typedef struct packed {
    logic [ODS_SYNC_STAGES:0] csSync;
    logic pushValid;
    ods_frame_s pushFrame;
    logic cmdReady;
    logic [CH_COUNT-1:0][7:0] codes;
    logic [ODS_MODE_BITS-1:0] mode;
    logic [CH_COUNT-1:0] buffered;
    logic [CH_COUNT-1:0] fullBuf;
  } ods_sys_s;

  ods_link_s lq;
  ods_link_s ld;
  ods_sys_s q;
  ods_sys_s d;

  logic fifoInReady;
  logic fifoOutValid;
  logic [ODS_FRAME_BITS-1:0] fifoOutData;
  logic fifoOutReady;
  ods_frame_s popFrame;
  logic popFire;
  ods_cmd_e popCmd;
  logic csRise;
  logic [CH_COUNT-1:0][7:0] codeNxt;
  logic [CH_COUNT-1:0] bufNxt;
  logic [CH_COUNT-1:0] fullNxt;
  logic [ODS_MODE_BITS-1:0] modeNxt;

  // link side

  always_comb
  begin
    ld = lq;
    // reset reaches this domain only while the serial clock runs
    ld.rstSync = {lq.rstSync[0], rst_n};
    if (!lq.rstSync[ODS_SYNC_STAGES-1])
    begin
      ld.shift = '0;
      ld.outOe = 1'b0;
    end
    else if (!chipSelectN && power_down_n)
    begin
      ld.shift = {lq.shift[ODS_FRAME_BITS-2:0], serialIn};
      // last stage is the bit from sixteen clocks back
      // output updates on this rising edge
      ld.outOe = !lq.shift[ODS_FRAME_BITS-1];
    end
  end

  always_ff @(posedge sclk)
  begin
    lq <= ld;
  end

  // open drain: only ever pulls low, pull-up gives the high level
  assign serialOutOut = 1'b0;
  assign serialOutOe = lq.outOe;

  // system side

  // select edge seen after synchronising, third stage only for the edge
  assign csRise = q.csSync[ODS_SYNC_STAGES-1] && !q.csSync[ODS_SYNC_STAGES];

  // select byte sits in the upper half, data in the lower
  assign popFrame = ods_frame_s'(fifoOutData);
  assign fifoOutReady = !updateHold;
  assign popFire = fifoOutValid && fifoOutReady;

  always_comb
  begin
    if (popFrame.chanSel != '0)
    begin
      popCmd = ODS_CMD_LOAD;
    end
    else if (popFrame.data[ODS_MODE_FLAG_BIT])
    begin
      popCmd = ODS_CMD_MODE;
    end
    else
    begin
      popCmd = ODS_CMD_NOP;
    end
  end

  // mode write copies data bits 5..0, bit 6 dropped
  // loads and no-ops keep the mode register
  assign modeNxt = (popFire && popCmd == ODS_CMD_MODE)
                   ? popFrame.data[ODS_MODE_BITS-1:0] : q.mode;

  genvar ch;
  generate
    for (ch = 0; ch < CH_COUNT; ch++)
    begin : g_chan
      localparam int EN_POS = (ch < 2) ? ODS_MODE_EN_01_POS :
                              (ch < 4) ? ODS_MODE_EN_23_POS :
                              (ch < 6) ? ODS_MODE_EN_45_POS : ODS_MODE_EN_67_POS;
      localparam int FULL_POS = (ch < 4) ? ODS_MODE_FULL_LO_POS : ODS_MODE_FULL_HI_POS;
      // selected channels take the data byte
      // select bit n drives channel n
      assign codeNxt[ch] = (popFire && popCmd == ODS_CMD_LOAD && popFrame.chanSel[ch])
                           ? popFrame.data : q.codes[ch];
      // pair enable from its own mode bit
      assign bufNxt[ch] = modeNxt[EN_POS];
      // full or half per channel group
      // ignored while the pair is unbuffered
      assign fullNxt[ch] = modeNxt[EN_POS] && modeNxt[FULL_POS];
    end
  endgenerate

  always_comb
  begin
    d = q;
    // pin enters through two flops before any logic reads it
    d.csSync = {q.csSync[ODS_SYNC_STAGES-1:0], chipSelectN};
    d.pushValid = 1'b0;
    d.cmdReady = fifoInReady;
    // capture the frame once select has risen
    if (csRise)
    begin
      // shift register is frozen while select is high, so this
      // cross-domain read is stable; a frame lost on a full FIFO
      // shows as cmdReady low beforehand
      d.pushValid = 1'b1;
      d.pushFrame = ods_frame_s'(lq.shift);
    end
    d.codes = codeNxt;
    d.mode = modeNxt;
    d.buffered = bufNxt;
    d.fullBuf = fullNxt;
    if (!rst_n)
    begin
      d.csSync = '1;
      d.pushValid = 1'b0;
      d.pushFrame = '0;
      d.cmdReady = 1'b0;
      d.codes = {CH_COUNT{ODS_CODE_RESET}};
      d.mode = ODS_MODE_RESET;
      d.buffered = '0;
      d.fullBuf = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    q <= d;
  end

  ods_frame_fifo #(
    .WIDTH(ODS_FRAME_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(q.pushValid),
    .inData(q.pushFrame),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(fifoOutReady)
  );

  assign cmdReady = q.cmdReady;
  assign chanCode = q.codes;
  assign output_stage_mode = q.mode;
  assign chanBuffered = q.buffered;
  assign chanFullBuffered = q.fullBuf;

endmodule : ods_serial_port

// [testbench/ods_link_host.sv]
// controller model on the serial link, with the pull-up on the chained output
`timescale 1ns/1ps
module ods_link_host (
  // link driven by the controller
  output logic sclk,
  output logic chipSelectN,
  output logic serialIn,
  // open-drain return
  input wire logic serialOutOe
);
  wire logic pinLevel = serialOutOe ? 1'b0 : 1'b1;
  initial
  begin
    sclk = 1'b0;
    chipSelectN = 1'b1;
    serialIn = 1'b0;
  end
  // deselected pulses, only to flush the link reset
  task automatic pulse(input int n);
    // odd offset keeps link edges off the system clock edges
    #0.7;
    repeat (n)
    begin
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask : pulse
  // select byte then data, msb first
  task automatic send(input logic [15:0] f, output logic [15:0] back);
    // link runs unrelated in phase to the system clock
    #0.7;
    // single device, short setup
    // chained parts need longer setup and period
    chipSelectN = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      serialIn = f[i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
      back[i] = pinLevel;
    end
    #24 chipSelectN = 1'b1;
    // released line must not look like a held bit
    serialIn = ~serialIn;
    #48;
  endtask : send
endmodule : ods_link_host

// [testbench/ods_serial_port_assertions.sv]
// checker for the serial command port
`timescale 1ns/1ps
module ods_serial_port_assertions
  import ods_pkg::*;
#(parameter int CH_COUNT = ODS_CH_COUNT)(
  // watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  input wire logic power_down_n,
  input wire logic serialOutOut,
  input wire logic serialOutOe,
  input wire logic updateHold,
  input wire logic cmdReady,
  input wire logic [CH_COUNT-1:0][7:0] chanCode,
  input wire logic [ODS_MODE_BITS-1:0] output_stage_mode,
  input wire logic [CH_COUNT-1:0] chanBuffered,
  input wire logic [CH_COUNT-1:0] chanFullBuffered
);
  wire logic [5:0] m = output_stage_mode;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  reset_clear_a:
    assert property ($rose(rst_n) |-> chanCode == '0 && m == '0 && !cmdReady ##1 cmdReady)
      else $error("state not cleared");
  pair_enable_a:
    assert property (chanBuffered == {{2{m[1]}}, {2{m[2]}}, {2{m[4]}}, {2{m[5]}}})
      else $error("pair enables wrong");
  full_half_a:
    assert property (chanFullBuffered == (chanBuffered & {{4{m[0]}}, {4{m[3]}}}))
      else $error("full select wrong");
  hold_freeze_a:
    assert property (updateHold [*5] |-> $stable(chanCode) && $stable(m))
      else $error("update while held");
  load_keeps_mode_a:
    assert property ($changed(chanCode) |-> $stable(m)) else $error("mode moved");
  mode_keeps_code_a:
    assert property ($changed(m) |-> $stable(chanCode)) else $error("codes moved");
  idle_link_a:
    assert property ($changed(serialOutOe) |-> !chipSelectN && power_down_n)
      else $error("shift while idle");
  out_edge_a:
    assert property ($changed(serialOutOe) |-> $rose(sclk)) else $error("output off edge");
  cover property ($changed(chanCode));
  cover property ($changed(m));
  cover property ($fell(cmdReady));
endmodule : ods_serial_port_assertions

bind ods_serial_port ods_serial_port_assertions #(.CH_COUNT(CH_COUNT)) ods_serial_port_assertions_i (.*);

// [testbench/ods_serial_port_bench.sv]
// bench for the serial command port
`timescale 1ns/1ps
module ods_serial_port_bench;
  import ods_pkg::*;
  logic clk, rst_n, sclk, chipSelectN, serialIn, power_down_n, serialOutOut, serialOutOe;
  logic updateHold, cmdReady;
  logic [7:0][7:0] chanCode;
  logic [5:0] output_stage_mode;
  logic [7:0] chanBuffered, chanFullBuffered;
  logic [15:0] prev, back;
  int n_fail, checked;
  ods_serial_port ods_serial_port_i (.*);
  ods_link_host ods_link_host_i (.sclk, .chipSelectN, .serialIn, .serialOutOe);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic frame(input logic [15:0] f);
    ods_link_host_i.send(f, back);
    chk("echo", 64'(back), 64'(prev));
    prev = f;
    tick(12);
  endtask : frame
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  initial
  begin
    rst_n = 1'b0;
    power_down_n = 1'b1;
    updateHold = 1'b0;
    n_fail = 0;
    checked = 0;
    prev = 16'h0000;
    tick(5);
    // link reset only lands on link edges
    ods_link_host_i.pulse(4);
    rst_n = 1'b1;
    tick(2);
    chk("code", chanCode, 64'h0);
    chk("mode", 64'(output_stage_mode), 64'h0);
    ods_link_host_i.send(16'h0000, back);
    tick(12);
    frame(16'hA54E);
    chk("code", chanCode, 64'h4E004E00004E004E);
    frame(16'h00F5);
    chk("mode", 64'(output_stage_mode), 64'h35);
    chk("buf", 64'(chanBuffered), 64'h3F);
    chk("full", 64'(chanFullBuffered), 64'h30);
    frame(16'h007F);
    chk("code", chanCode, 64'h4E004E00004E004E);
    frame(16'hBF11);
    chk("code", chanCode, 64'h1100111111111111);
    chk("mode", 64'(output_stage_mode), 64'h35);
    power_down_n = 1'b0;
    ods_link_host_i.send(16'hFF22, back);
    tick(1);
    power_down_n = 1'b1;
    tick(12);
    chk("code", chanCode, 64'h1100111111111111);
    updateHold = 1'b1;
    for (int i = 0; i < 17; i++)
      frame({8'h01, 8'(i)});
    chk("ready", 64'(cmdReady), 64'h0);
    updateHold = 1'b0;
    tick(40);
    chk("ready", 64'(cmdReady), 64'h1);
    chk("code", chanCode, 64'h110011111111110F);
    final_report();
  end
endmodule : ods_serial_port_bench
